/* File: src/arpc_consts.svh */
// Operation
// (RULE_01) Window mode code picks above, below, inside or outside comparison; 0 disables.
// (RULE_02) Resolution code picks 12, 16 (averaging), 10 or 8 bit results.
// (RULE_03) Correction enable applies gain and offset trim before storing the result.
// (RULE_04) With correction enabled each conversion takes 13 extra cycles.
// (RULE_05) Continuous bit restarts conversion after each completes; clear means single.
// (RULE_06) Left align bit moves the result to the top of the result register.
// (RULE_07) Differential bit converts positive minus negative input instead of single-ended.
// (RULE_08) Shift field divides the accumulated sum by two to its power.
// (RULE_09) Count field sums two to its power samples, up to 1024.
// (RULE_10) Software widens the resolution when accumulation widens the result.
// (RULE_11) Drift compensation runs every sampling phase and adds three cycles.
// (RULE_12) Software keeps compensation off whenever sampling length is nonzero.
// (RULE_13) Sampling phase lasts sampling length plus one cycles.
// (RULE_14) Lower threshold register is the window lower bound.
// (RULE_15) Window flag sets the cycle after a matching result; interrupt if enabled.
// (RULE_16) Upper threshold register is the window upper bound.
// (RULE_17) Gain trim is unsigned, one integer bit and eleven fraction bits.
// (RULE_18) Offset trim is a signed two's complement value.
// (RULE_19) Reserved window codes disable; reserved count codes mean one sample.
`ifndef ARPC_CONSTS_SVH
`define ARPC_CONSTS_SVH
// ==========================================================
// Register offsets
`define ARPC_OFF_CTRL    8'h0a
`define ARPC_OFF_AVG     8'h0c
`define ARPC_OFF_SAMP    8'h0d
`define ARPC_OFF_WINLO   8'h0e
`define ARPC_OFF_WINHI   8'h10
`define ARPC_OFF_GAIN    8'h12
`define ARPC_OFF_OFFS    8'h14
`define ARPC_OFF_STAT    8'h20
`define ARPC_OFF_ICLR    8'h21
`define ARPC_OFF_IEN     8'h22
`define ARPC_OFF_RESULT  8'h24
`define ARPC_OFF_CMD     8'h26
// ==========================================================
// Write masks and reset values
`define ARPC_CTRL_MASK   16'h073f
`define ARPC_AVG_MASK    8'h7f
`define ARPC_SAMP_MASK   8'hbf
`define ARPC_RST16       16'h0000
`define ARPC_RST8        8'h00
// ==========================================================
// Field codes
`define ARPC_WIN_OFF     3'h0
`define ARPC_WIN_ABOVE   3'h1
`define ARPC_WIN_BELOW   3'h2
`define ARPC_WIN_INSIDE  3'h3
`define ARPC_WIN_OUTSIDE 3'h4
`define ARPC_RES_12      2'h0
`define ARPC_RES_16      2'h1
`define ARPC_RES_10      2'h2
`define ARPC_RES_8       2'h3
`define ARPC_CNT_MAX     4'ha
`define ARPC_GAIN_FRAC   11
// ==========================================================
// Status bit positions and command bit
`define ARPC_ST_RDY      0
`define ARPC_ST_OVR      1
`define ARPC_ST_WIN      2
`define ARPC_CMD_START   0
// ==========================================================
// Timing counts in converter clock cycles
`define ARPC_CORR_CYCLES 13
`define ARPC_COMP_CYCLES 3
`endif

/* File: src/arpc_pkg.sv */
package arpc_pkg;
  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ARPC_IDLE,
    ARPC_SAMPLE,
    ARPC_CONVERT,
    ARPC_CORRECT,
    ARPC_STORE
  } arpc_state_t;

  // ==========================================================
  // Conversion control layout
  typedef struct packed {
    logic [4:0] rsv_hi;
    logic [2:0] window_compare_select;
    logic [1:0] rsv_mid;
    logic [1:0] result_width_select;
    logic       correction_enable;
    logic       continuous_conversion;
    logic       left_align_result;
    logic       differential_input;
  } arpc_ctrl_t;

  // Averaging control layout
  typedef struct packed {
    logic       rsv;
    logic [2:0] sum_divide_shift;
    logic [3:0] accumulate_count;
  } arpc_avg_t;

  // Sampling time control layout
  typedef struct packed {
    logic       comparator_drift_compensation;
    logic       rsv;
    logic [5:0] sampling_length;
  } arpc_samp_t;
endpackage : arpc_pkg

/* File: src/arpc_corr.sv */
`timescale 1ns/1ns
`default_nettype none
`include "arpc_consts.svh"
module arpc_corr (
  // Value in and trims
  input  wire logic [15:0] value,
  input  wire logic [11:0] gain_trim,
  input  wire logic [11:0] offset_trim,
  input  wire logic [15:0] max_code,
  // Corrected value
  output logic      [15:0] corrected
);
  logic signed [17:0] diff;
  logic signed [31:0] prod;
  logic signed [31:0] scaled;

  // ==========================================================
  // Offset subtract, gain multiply, clamp to resolution
  always_comb begin
    // (RULE_18) Signed offset trim
    diff   = $signed({2'h0, value}) - $signed({{6{offset_trim[11]}}, offset_trim});
    // (RULE_17) Gain as 1.11 unsigned
    prod   = 32'(diff) * $signed({20'h00000, gain_trim});
    scaled = prod >>> `ARPC_GAIN_FRAC;
    if (scaled < 0) begin
      corrected = 16'h0000;
    end else if (scaled > $signed({16'h0000, max_code})) begin
      corrected = max_code;
    end else begin
      corrected = scaled[15:0];
    end
  end
endmodule : arpc_corr
`default_nettype wire

/* File: src/arpc_top.sv */
// Chosen here: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "arpc_consts.svh"
module arpc_top
  import arpc_pkg::*;
#(
  parameter int ACC_W = 24
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  // Analog core
  output logic             sample_hold,
  output logic             drift_comp,
  output logic             conv_start,
  output logic             diff_sel,
  output logic      [1:0]  width_sel,
  input  wire logic        raw_valid,
  input  wire logic [11:0] raw_data,
  // Interrupt
  output logic             irq
);
  // ==========================================================
  // Parameter check
  if (ACC_W < 22 || ACC_W > 32) begin : g_chk
    $error("ACC_W must be 22 to 32");
  end

  arpc_ctrl_t  ctrl;
  arpc_avg_t   avg;
  arpc_samp_t  samp;
  logic [15:0] win_lo;
  logic [15:0] win_hi;
  logic [11:0] gain;
  logic [11:0] offs;
  logic [2:0]  status;
  logic [2:0]  ien;
  logic [15:0] result;
  logic        unread;
  arpc_state_t state;
  arpc_state_t next_state;
  logic [6:0]  cnt;
  logic [10:0] scnt;
  logic [ACC_W-1:0] acc;
  logic [15:0] avg_val;
  logic [15:0] corr_val;
  logic [15:0] final_val;
  logic        win_hit;
  logic        start_req;
  logic        res_read;
  logic [10:0] n_last;

  // ==========================================================
  // Helper functions
  function automatic logic [15:0] res_max(input logic [1:0] r);
    case (r)
      `ARPC_RES_10: res_max = 16'h03ff;
      `ARPC_RES_8:  res_max = 16'h00ff;
      `ARPC_RES_16: res_max = 16'hffff;
      default:      res_max = 16'h0fff;
    endcase
  endfunction : res_max

  function automatic logic [3:0] left_shift(input logic [1:0] r);
    case (r)
      `ARPC_RES_10: left_shift = 4'h6;
      `ARPC_RES_8:  left_shift = 4'h8;
      `ARPC_RES_16: left_shift = 4'h0;
      default:      left_shift = 4'h4;
    endcase
  endfunction : left_shift

  function automatic logic [ACC_W-1:0] scale_raw(input logic [11:0] v, input logic [1:0] r,
                                                 input logic d);
    logic [11:0] s;
    s = v;
    case (r)
      `ARPC_RES_10: s = d ? {{2{v[11]}}, v[11:2]} : {2'h0, v[11:2]};
      `ARPC_RES_8:  s = d ? {{4{v[11]}}, v[11:4]} : {4'h0, v[11:4]};
      default:      s = v;
    endcase
    // Differential samples are two's complement
    scale_raw = d ? {{(ACC_W-12){s[11]}}, s} : {{(ACC_W-12){1'b0}}, s};
  endfunction : scale_raw

  // ==========================================================
  // Decoded strobes and sample count
  assign start_req = wr && addr == `ARPC_OFF_CMD && wdata[`ARPC_CMD_START];
  assign res_read  = rd && addr == `ARPC_OFF_RESULT;
  // (RULE_09) Two to the count samples; (RULE_19) reserved count means one
  assign n_last    = (avg.accumulate_count > `ARPC_CNT_MAX) ? 11'h000
                   : 11'((12'h001 << avg.accumulate_count) - 12'h001);

  // (RULE_08) Divide accumulated sum by two to the shift
  // Both arms signed so the arithmetic shift keeps the sign of differential sums
  assign avg_val = 16'(ctrl.differential_input ? ($signed(acc) >>> avg.sum_divide_shift)
                                               : $signed(acc >> avg.sum_divide_shift));

  arpc_corr u_corr (
    .value       (avg_val),
    .gain_trim   (gain),
    .offset_trim (offs),
    .max_code    (res_max(ctrl.result_width_select)),
    .corrected   (corr_val)
  );

  // (RULE_03) Corrected value only when correction enabled
  assign final_val = ctrl.correction_enable ? corr_val : avg_val;

  // ==========================================================
  // Window comparison
  always_comb begin
    // (RULE_14) Lower bound and (RULE_16) upper bound
    case (ctrl.window_compare_select)
      `ARPC_WIN_ABOVE:   win_hit = final_val > win_lo;
      `ARPC_WIN_BELOW:   win_hit = final_val < win_hi;
      `ARPC_WIN_INSIDE:  win_hit = final_val > win_lo && final_val < win_hi;
      `ARPC_WIN_OUTSIDE: win_hit = final_val < win_lo || final_val > win_hi;
      // (RULE_01) Off; (RULE_19) reserved codes also off
      default:           win_hit = 1'b0;
    endcase
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl   <= arpc_ctrl_t'(`ARPC_RST16);
      avg    <= arpc_avg_t'(`ARPC_RST8);
      samp   <= arpc_samp_t'(`ARPC_RST8);
      win_lo <= `ARPC_RST16;
      win_hi <= `ARPC_RST16;
      gain   <= 12'h000;
      offs   <= 12'h000;
      ien    <= 3'h0;
    end else if (wr) begin
      case (addr)
        `ARPC_OFF_CTRL:  ctrl   <= arpc_ctrl_t'(wdata & `ARPC_CTRL_MASK);
        `ARPC_OFF_AVG:   avg    <= arpc_avg_t'(wdata[7:0] & `ARPC_AVG_MASK);
        `ARPC_OFF_SAMP:  samp   <= arpc_samp_t'(wdata[7:0] & `ARPC_SAMP_MASK);
        `ARPC_OFF_WINLO: win_lo <= wdata;
        `ARPC_OFF_WINHI: win_hi <= wdata;
        `ARPC_OFF_GAIN:  gain   <= wdata[11:0];
        `ARPC_OFF_OFFS:  offs   <= wdata[11:0];
        `ARPC_OFF_IEN:   ien    <= wdata[2:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      ARPC_IDLE:    if (start_req) next_state = ARPC_SAMPLE;
      ARPC_SAMPLE:  if (cnt == 7'h00) next_state = ARPC_CONVERT;
      ARPC_CONVERT: begin
        if (raw_valid) begin
          if (scnt != n_last) begin
            next_state = ARPC_SAMPLE;
          end else if (ctrl.correction_enable) begin
            next_state = ARPC_CORRECT;
          end else begin
            next_state = ARPC_STORE;
          end
        end
      end
      ARPC_CORRECT: if (cnt == 7'h00) next_state = ARPC_STORE;
      // (RULE_05) Continuous restarts, single returns to idle
      ARPC_STORE:   next_state = (ctrl.continuous_conversion || start_req) ? ARPC_SAMPLE
                                                                           : ARPC_IDLE;
      default:      next_state = ARPC_IDLE;
    endcase
  end

  // Sequencer state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ARPC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Phase counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt <= 7'h00;
    end else if (next_state == ARPC_SAMPLE && state != ARPC_SAMPLE) begin
      // (RULE_13) Length plus one; (RULE_11) compensation loads three in place of the length
      cnt <= samp.comparator_drift_compensation ? 7'(`ARPC_COMP_CYCLES)
                                                : {1'b0, samp.sampling_length};
    end else if (next_state == ARPC_CORRECT && state != ARPC_CORRECT) begin
      // (RULE_04) Thirteen correction cycles
      cnt <= 7'(`ARPC_CORR_CYCLES - 1);
    end else if (cnt != 7'h00) begin
      cnt <= cnt - 7'h01;
    end
  end

  // ==========================================================
  // Sample accumulation
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc  <= '0;
      scnt <= 11'h000;
    end else if (state == ARPC_STORE || state == ARPC_IDLE) begin
      acc  <= '0;
      scnt <= 11'h000;
    end else if (state == ARPC_CONVERT && raw_valid) begin
      // (RULE_07) Signed samples in differential mode
      acc  <= acc + scale_raw(raw_data, ctrl.result_width_select, ctrl.differential_input);
      scnt <= scnt + 11'h001;
    end
  end

  // ==========================================================
  // Result register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result <= `ARPC_RST16;
    end else if (state == ARPC_STORE) begin
      // (RULE_06) Left or right alignment; (RULE_02) width per resolution
      result <= ctrl.left_align_result ? 16'(final_val << left_shift(ctrl.result_width_select))
                                       : (final_val & res_max(ctrl.result_width_select));
    end
  end

  // Unread tracking, store wins over read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      unread <= 1'b0;
    end else if (state == ARPC_STORE) begin
      unread <= 1'b1;
    end else if (res_read) begin
      unread <= 1'b0;
    end
  end

  // ==========================================================
  // Sticky status, set wins over clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status <= 3'h0;
    end else begin
      status[`ARPC_ST_RDY] <= (state == ARPC_STORE) ||
        (status[`ARPC_ST_RDY] && !res_read &&
         !(wr && addr == `ARPC_OFF_ICLR && wdata[`ARPC_ST_RDY]));
      status[`ARPC_ST_OVR] <= (state == ARPC_STORE && unread) ||
        (status[`ARPC_ST_OVR] && !(wr && addr == `ARPC_OFF_ICLR && wdata[`ARPC_ST_OVR]));
      // (RULE_15) Window flag on the cycle after the match
      status[`ARPC_ST_WIN] <= (state == ARPC_STORE && win_hit) ||
        (status[`ARPC_ST_WIN] && !res_read &&
         !(wr && addr == `ARPC_OFF_ICLR && wdata[`ARPC_ST_WIN]));
    end
  end

  // Interrupt level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & ien);
    end
  end

  // ==========================================================
  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      case (addr)
        `ARPC_OFF_CTRL:   rdata <= ctrl;
        `ARPC_OFF_AVG:    rdata <= {8'h00, avg};
        `ARPC_OFF_SAMP:   rdata <= {8'h00, samp};
        `ARPC_OFF_WINLO:  rdata <= win_lo;
        `ARPC_OFF_WINHI:  rdata <= win_hi;
        `ARPC_OFF_GAIN:   rdata <= {4'h0, gain};
        `ARPC_OFF_OFFS:   rdata <= {4'h0, offs};
        `ARPC_OFF_STAT:   rdata <= {13'h0000, status};
        `ARPC_OFF_IEN:    rdata <= {13'h0000, ien};
        `ARPC_OFF_RESULT: rdata <= result;
        default:          rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

  // ==========================================================
  // Analog core controls
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sample_hold <= 1'b0;
      drift_comp  <= 1'b0;
      conv_start  <= 1'b0;
      diff_sel    <= 1'b0;
      width_sel   <= 2'h0;
    end else begin
      sample_hold <= next_state == ARPC_SAMPLE;
      // (RULE_11) Compensation in every sampling phase
      drift_comp  <= next_state == ARPC_SAMPLE && samp.comparator_drift_compensation;
      conv_start  <= next_state == ARPC_CONVERT && state == ARPC_SAMPLE;
      // (RULE_07) Differential select to core
      diff_sel    <= ctrl.differential_input;
      width_sel   <= ctrl.result_width_select;
    end
  end

  // ==========================================================
  // Helper counters for checks
  logic [7:0] hold_run;
  logic [7:0] hold_exp;
  logic [7:0] corr_run;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_run <= 8'h00;
      hold_exp <= 8'h00;
      corr_run <= 8'h00;
    end else begin
      hold_run <= (state == ARPC_SAMPLE) ? hold_run + 8'h01 : 8'h00;
      // Cycles spent in the correction wait, independent of the phase counter
      corr_run <= (state == ARPC_CORRECT) ? corr_run + 8'h01 : 8'h00;
      if (state != ARPC_SAMPLE && next_state == ARPC_SAMPLE) begin
        hold_exp <= samp.comparator_drift_compensation ? 8'(`ARPC_COMP_CYCLES + 1)
                                                       : 8'(samp.sampling_length + 6'h01);
      end
    end
  end

  a_sample_len: assert property (@(posedge clk) disable iff (!rst_n) // (RULE_13)
    (state == ARPC_SAMPLE && next_state != ARPC_SAMPLE) |-> hold_run + 8'h01 == hold_exp)
    else $error("sampling phase length wrong");

  a_comp_len: assert property (@(posedge clk) disable iff (!rst_n) // (RULE_11)
    (state == ARPC_IDLE && start_req && samp.comparator_drift_compensation)
    |=> (state == ARPC_SAMPLE && drift_comp)[*4] ##1 state == ARPC_CONVERT)
    else $error("compensated sampling not four cycles");

  a_corr_delay: assert property (@(posedge clk) disable iff (!rst_n) // (RULE_04)
    (state == ARPC_CORRECT && next_state != ARPC_CORRECT)
    |-> corr_run == 8'(`ARPC_CORR_CYCLES - 1) ##1 state == ARPC_STORE)
    else $error("correction delay not thirteen cycles");

  a_no_corr: assert property (@(posedge clk) disable iff (!rst_n) // (RULE_03)
    (state == ARPC_STORE && !ctrl.correction_enable) |-> $past(state) == ARPC_CONVERT)
    else $error("correction wait without enable");

  a_cont_restart: assert property (@(posedge clk) disable iff (!rst_n) // (RULE_05)
    (state == ARPC_STORE && ctrl.continuous_conversion) |=> state == ARPC_SAMPLE)
    else $error("continuous mode did not restart");

  a_single_stop: assert property (@(posedge clk) disable iff (!rst_n) // (RULE_05)
    (state == ARPC_STORE && !ctrl.continuous_conversion && !start_req) |=> state == ARPC_IDLE)
    else $error("single mode did not stop");

  a_win_lower: assert property (@(posedge clk) disable iff (!rst_n) // (RULE_14)
    (state == ARPC_STORE && ctrl.window_compare_select == `ARPC_WIN_ABOVE && final_val > win_lo)
    |=> status[`ARPC_ST_WIN])
    else $error("lower bound match missed");

  a_win_upper: assert property (@(posedge clk) disable iff (!rst_n) // (RULE_16)
    (state == ARPC_STORE && ctrl.window_compare_select == `ARPC_WIN_BELOW && final_val < win_hi)
    |=> status[`ARPC_ST_WIN])
    else $error("upper bound match missed");

  a_win_off: assert property (@(posedge clk) disable iff (!rst_n) // (RULE_19)
    (state == ARPC_STORE && (ctrl.window_compare_select == `ARPC_WIN_OFF ||
     ctrl.window_compare_select > `ARPC_WIN_OUTSIDE)) |=> !$rose(status[`ARPC_ST_WIN]))
    else $error("window flag set while disabled");

  a_left_align: assert property (@(posedge clk) disable iff (!rst_n) // (RULE_06)
    (state == ARPC_STORE && ctrl.left_align_result &&
     ctrl.result_width_select == `ARPC_RES_12) |=> result[3:0] == 4'h0)
    else $error("left aligned result low bits not zero");

  a_irq_level: assert property (@(posedge clk) disable iff (!rst_n) // (RULE_15)
    ##1 irq == |($past(status) & $past(ien)))
    else $error("interrupt level mismatch");
endmodule : arpc_top
`default_nettype wire

/* File: verification/arpc_core_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Analog core stand-in
module arpc_core_model (
  // Clock and request
  input  wire logic        clk,
  input  wire logic        conv_start,
  // Value to return and pace
  input  wire logic [11:0] smp,
  input  wire logic        slow,
  // Answer
  output logic             raw_valid,
  output logic      [11:0] raw_data
);
  logic [1:0] pipe = 2'b00;
  initial raw_valid = 1'b0;
  initial raw_data = 12'h5a5;
  // One answer per request, two or three cycles late; junk on data otherwise
  always @(posedge clk) begin
    pipe      <= {pipe[0], conv_start};
    raw_valid <= slow ? pipe[1] : pipe[0];
    raw_data  <= (slow ? pipe[1] : pipe[0]) ? smp : ~raw_data;
  end
endmodule : arpc_core_model
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
  // ==========================================================
  // Stimulus, model and design
  typedef struct packed {
    logic [15:0] ctrl;
    logic [7:0]  avg;
    logic [7:0]  samp;
    logic [11:0] gain;
    logic [11:0] offs;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [11:0] smp;
    logic [15:0] res;
    logic        win;
  } arpc_row_t;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [11:0] smp = 12'h000;
  logic        slow = 1'b0;
  logic        dbl = 1'b0;
  wire  [15:0] rdata;
  wire         sample_hold, drift_comp, conv_start, diff_sel, raw_valid, irq;
  wire  [1:0]  width_sel;
  wire  [11:0] raw_data;
  int          error_cnt = 0;
  int          compares = 0;
  int          holds, comps, starts, gap, i;
  // Address, write value, read-back value
  logic [39:0] regs [12] = '{40'h0a_ffff_073f, 40'h0c_00ff_007f, 40'h0d_00ff_00bf,
    40'h0e_ffff_ffff, 40'h10_ffff_ffff, 40'h12_ffff_0fff, 40'h14_ffff_0fff,
    40'h20_ffff_0000, 40'h21_0000_0000, 40'h22_ffff_0007, 40'h24_ffff_0000,
    40'h30_ffff_0000};
  // Setup, sample and expected result with window flag
  arpc_row_t rows [19] = '{
    '{16'h0000, 8'h00, 8'h00, 12'h800, 12'h0, 16'h0, 16'h0, 12'habc, 16'h0abc, 1'b0},
    '{16'h0002, 8'h00, 8'h00, 12'h800, 12'h0, 16'h0, 16'h0, 12'habc, 16'habc0, 1'b0},
    '{16'h0020, 8'h00, 8'h00, 12'h800, 12'h0, 16'h0, 16'h0, 12'habc, 16'h02af, 1'b0},
    '{16'h0030, 8'h00, 8'h00, 12'h800, 12'h0, 16'h0, 16'h0, 12'habc, 16'h00ab, 1'b0},
    '{16'h0032, 8'h00, 8'h00, 12'h800, 12'h0, 16'h0, 16'h0, 12'habc, 16'hab00, 1'b0},
    '{16'h0010, 8'h22, 8'h05, 12'h800, 12'h0, 16'h0, 16'h0, 12'habc, 16'h0abc, 1'b0},
    '{16'h0010, 8'h7a, 8'h00, 12'h800, 12'h0, 16'h0, 16'h0, 12'habc, 16'h55e0, 1'b0},
    '{16'h0000, 8'h0b, 8'h80, 12'h800, 12'h0, 16'h0, 16'h0, 12'habc, 16'h0abc, 1'b0},
    '{16'h0011, 8'h11, 8'h00, 12'h800, 12'h0, 16'h0, 16'h0, 12'hfff, 16'hffff, 1'b0},
    '{16'h0008, 8'h00, 8'h00, 12'h800, 12'h010, 16'h0, 16'h0, 12'habc, 16'h0aac, 1'b0},
    '{16'h0008, 8'h00, 8'h00, 12'hc00, 12'hff0, 16'h0, 16'h0, 12'h400, 16'h0618, 1'b0},
    '{16'h0100, 8'h00, 8'h00, 12'h800, 12'h0, 16'habb, 16'h0, 12'habc, 16'h0abc, 1'b1},
    '{16'h0100, 8'h00, 8'h00, 12'h800, 12'h0, 16'habc, 16'h0, 12'habc, 16'h0abc, 1'b0},
    '{16'h0200, 8'h00, 8'h00, 12'h800, 12'h0, 16'h0, 16'habd, 12'habc, 16'h0abc, 1'b1},
    '{16'h0300, 8'h00, 8'h00, 12'h800, 12'h0, 16'habb, 16'habd, 12'habc, 16'h0abc, 1'b1},
    '{16'h0300, 8'h00, 8'h00, 12'h800, 12'h0, 16'habc, 16'habd, 12'habc, 16'h0abc, 1'b0},
    '{16'h0400, 8'h00, 8'h00, 12'h800, 12'h0, 16'hb00, 16'hc00, 12'habc, 16'h0abc, 1'b1},
    '{16'h0500, 8'h00, 8'h00, 12'h800, 12'h0, 16'h0, 16'hffff, 12'habc, 16'h0abc, 1'b0},
    '{16'h0000, 8'h00, 8'h00, 12'h800, 12'h0, 16'h0, 16'hffff, 12'habc, 16'h0abc, 1'b0}};

  arpc_top dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sample_hold(sample_hold), .drift_comp(drift_comp),
    .conv_start(conv_start), .diff_sel(diff_sel), .width_sel(width_sel),
    .raw_valid(raw_valid), .raw_data(raw_data), .irq(irq));
  arpc_core_model core (.clk(clk), .conv_start(conv_start), .smp(smp), .slow(slow),
    .raw_valid(raw_valid), .raw_data(raw_data));

  // Free-running clock
  initial begin
    forever #4 clk = ~clk;
  end

  // ==========================================================
  // Helpers
  function automatic int nsmp(input logic [3:0] c);
    return (c > 4'ha) ? 1 : (1 << c);
  endfunction : nsmp
  task automatic stop_test();
    if (error_cnt == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rd_reg
  // Start a conversion and count core activity until the interrupt
  task automatic go();
    holds  = dbl ? 2 : 0; // Two sampling cycles pass during the refused second start
    comps  = 0;
    starts = 0;
    gap    = 0;
    wr_reg(8'h26, 16'h0001);
    if (dbl)
      wr_reg(8'h26, 16'h0001);
    for (i = 0; i < 20000 && !irq; i++) begin
      #1;
      holds  += sample_hold;
      comps  += drift_comp;
      starts += conv_start;
      gap     = raw_valid ? 0 : gap + 1;
      @(posedge clk);
    end
    if (irq !== 1'b1) begin
      error_cnt++;
      stop_test();
    end
  endtask : go
  task automatic run_row(input arpc_row_t r);
    smp <= r.smp;
    wr_reg(8'h0a, r.ctrl);
    wr_reg(8'h0c, {8'h00, r.avg});
    wr_reg(8'h0d, {8'h00, r.samp});
    wr_reg(8'h0e, r.lo);
    wr_reg(8'h10, r.hi);
    wr_reg(8'h12, {4'h0, r.gain});
    wr_reg(8'h14, {4'h0, r.offs});
    go();
    chk(16'(holds), 16'(nsmp(r.avg[3:0]) * (r.samp[7] ? 4 : r.samp[5:0] + 1)));
    chk(16'(comps), r.samp[7] ? 16'(holds) : 16'h0000);
    chk(16'(starts), 16'(nsmp(r.avg[3:0])));
    chk(16'(gap), r.ctrl[3] ? 16'h0010 : 16'h0003);
    chk({14'h0, width_sel}, {14'h0, r.ctrl[5:4]});
    chk({15'h0, diff_sel}, {15'h0, r.ctrl[0]});
    rd_reg(8'h20, {13'h0, r.win, 2'b01});
    rd_reg(8'h24, r.res);
    rd_reg(8'h20, 16'h0000);
  endtask : run_row

  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    foreach (regs[k]) begin
      rd_reg(regs[k][39:32], 16'h0000);
      wr_reg(regs[k][39:32], regs[k][31:16]);
      rd_reg(regs[k][39:32], regs[k][15:0]);
    end
    foreach (rows[k]) begin
      slow <= k[0];
      run_row(rows[k]);
    end
    dbl = 1'b1;
    run_row('{16'h0, 8'h0, 8'h14, 12'h800, 12'h0, 16'h0, 16'h0, 12'h123, 16'h0123, 1'b0});
    dbl = 1'b0;
    // Continuous mode leaves a result unread and raises overrun
    wr_reg(8'h22, 16'h0002);
    wr_reg(8'h0d, 16'h0000);
    wr_reg(8'h0a, 16'h0004);
    wr_reg(8'h26, 16'h0001);
    repeat (40) @(posedge clk);
    #1;
    chk({15'h0, irq}, 16'h0001);
    wr_reg(8'h0a, 16'h0000);
    repeat (20) @(posedge clk);
    rd_reg(8'h20, 16'h0003);
    rd_reg(8'h24, 16'h0123);
    rd_reg(8'h20, 16'h0002);
    wr_reg(8'h22, 16'h0000);
    rd_reg(8'h20, 16'h0002);
    chk({15'h0, irq}, 16'h0000);
    wr_reg(8'h21, 16'h0002);
    rd_reg(8'h20, 16'h0000);
    // Reset in mid-conversion
    wr_reg(8'h0d, 16'h0014);
    wr_reg(8'h26, 16'h0001);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk({15'h0, sample_hold}, 16'h0000);
    rd_reg(8'h0d, 16'h0000);
    stop_test();
  end
endmodule : tb
`default_nettype wire
